//--- rtl/scs_regs.svh
// Operation
// RULE1: Self-initialisation ends within 50 microseconds after reset
// RULE2: Defaults loaded into six registers at completion
// RULE3: Host writes all registers without a default
// RULE4: Host waits 50 microseconds before first access
// RULE5: Host first programs both clock-source select bits
// RULE6: Host reads select bits back, rewrites on mismatch
// RULE7: Hold release high-to-low starts clock generation
// RULE8: Cleared hold bit cannot be set again
// RULE9: Bus-filter bit low gives strongest noise suppression
// RULE10: Clock generation held until hold first released
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SCS_INIT_TIME_NS    50000
`define SCS_CLK_PERIOD_NS   50
// Longest time, so the division rounds down
`define SCS_INIT_CYCLES     (`SCS_INIT_TIME_NS / `SCS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Field positions of the sync_config_reg register
// ----------------------------------------------------------------------------
`define SCS_SYNC_SEL0_POS   0
`define SCS_SYNC_SEL1_POS   1
`define SCS_SYNC_FILT_POS   7

// ----------------------------------------------------------------------------
// Field positions of the level/change register
// ----------------------------------------------------------------------------
`define SCS_LEVEL_HOLD_POS  7

// ----------------------------------------------------------------------------
// Default values loaded after self-initialisation
// ----------------------------------------------------------------------------
`define SCS_ADR_PTR0_RST    8'h00
`define SCS_ADR_PTR1_RST    8'h00
`define SCS_DATA_PORT_RST   8'h00
`define SCS_ACQ_CTRL_RST    8'h00
`define SCS_SYNC_CFG_RST    8'h80
`define SCS_LEVEL_CHG_RST   8'h80
// Value held before defaults are loaded
`define SCS_REG_CLEAR       8'h00

`endif

//--- rtl/scs_pkg.sv
`default_nettype none
package scs_pkg;
   // Sequencer states
   typedef enum logic [1:0] {
      SCS_ST_INIT = 2'b00, // Self-initialisation running
      SCS_ST_HELD = 2'b01, // Ready, clock generation held
      SCS_ST_RUN  = 2'b10  // Clock generation released
   } scs_state_t;

   // Clock-source selection codes
   typedef logic [1:0] scs_clk_sel_t;
endpackage
`default_nettype wire

//--- rtl/scs_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "scs_regs.svh"

module scs_timer #(
   parameter int unsigned LIMIT = `SCS_INIT_CYCLES
) (
   input  wire logic clk_i,   // System clock
   input  wire logic resetn_i,// Synchronous reset, active low
   output logic      done_o   // High once LIMIT cycles have passed
);
   localparam int unsigned CW = $clog2(LIMIT + 1);

   logic [CW-1:0] cnt_ff;     // Cycles since reset
   logic [CW-1:0] nxt_cnt;
   logic          done_ff;    // Terminal flag
   logic          nxt_done;

   // ------------------------------------------------------------------------
   // Next count, saturating at the limit
   // ------------------------------------------------------------------------
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_done = done_ff;
      if (!done_ff) begin
         nxt_cnt = cnt_ff + CW'(1);
         // Done on the edge that completes LIMIT cycles
         if (cnt_ff == CW'(LIMIT - 1)) begin
            nxt_done = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign done_o = done_ff;
endmodule
`default_nettype wire

//--- rtl/scs_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "scs_regs.svh"

module scs_seq #(
   parameter int unsigned INIT_CYCLES = `SCS_INIT_CYCLES
) (
   input  wire logic       clk_i,          // System clock, 20 MHz
   input  wire logic       resetn_i,       // Synchronous reset, active low
   input  wire logic       sync_wr_i,      // Host write to sync_config_reg
   input  wire logic [7:0] sync_wdata_i,   // Data for sync_config_reg
   input  wire logic       level_wr_i,     // Host write to level_change_reg
   input  wire logic [7:0] level_wdata_i,  // Data for level_change_reg
   output logic            ready_o,        // Self-initialisation done
   output logic [7:0]      adr_ptr0_o,     // Address pointer 0
   output logic [7:0]      adr_ptr1_o,     // Address pointer 1
   output logic [7:0]      data_port_o,    // Data port
   output logic [7:0]      acq_ctrl_o,     // acquisition_ctrl_reg
   output logic [7:0]      sync_cfg_o,     // sync_config_reg readback
   output logic [7:0]      level_chg_o,    // level_change_reg readback
   output logic            clkgen_init_o,  // One-cycle clock generator start
   output logic            clkgen_run_o,   // Clock generation running
   output logic [1:0]      clkgen_sel_o,   // Source applied to clock generation
   output logic            filter_max_o    // Strongest bus noise suppression
);
   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   scs_pkg::scs_state_t   state_ff;        // Sequencer state
   scs_pkg::scs_state_t   nxt_state;
   logic [7:0]            adr0_ff;         // Address pointer 0
   logic [7:0]            nxt_adr0;
   logic [7:0]            adr1_ff;         // Address pointer 1
   logic [7:0]            nxt_adr1;
   logic [7:0]            dport_ff;        // Data port
   logic [7:0]            nxt_dport;
   logic [7:0]            acq_ff;          // Acquisition control
   logic [7:0]            nxt_acq;
   logic [7:0]            sync_ff;         // Sync_config_reg register
   logic [7:0]            nxt_sync;
   logic [7:0]            level_ff;        // Level/change register
   logic [7:0]            nxt_level;
   logic                  ready_ff;        // Ready for host access
   logic                  nxt_ready;
   logic                  init_ff;         // Clock generator start pulse
   logic                  nxt_init;
   logic                  run_ff;          // Clock generation running
   logic                  nxt_run;
   scs_pkg::scs_clk_sel_t gsel_ff;         // Applied clock source
   scs_pkg::scs_clk_sel_t nxt_gsel;
   logic                  filt_ff;         // Strong filter active
   logic                  nxt_filt;
   logic                  timer_done;      // Init period elapsed
   logic                  hold_now;        // Current hold bit
   logic                  hold_req;        // Hold bit being written

   // ------------------------------------------------------------------------
   // Self-initialisation timer
   // ------------------------------------------------------------------------
   // Done one cycle early, so ready lands on edge INIT_CYCLES, not later [RULE1]
   scs_timer #(
      .LIMIT (INIT_CYCLES - 1)
   ) u_timer (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .done_o   (timer_done)
   );

   assign hold_now = level_ff[`SCS_LEVEL_HOLD_POS];
   assign hold_req = level_wdata_i[`SCS_LEVEL_HOLD_POS];

   // ------------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_adr0  = adr0_ff;
      nxt_adr1  = adr1_ff;
      nxt_dport = dport_ff;
      nxt_acq   = acq_ff;
      nxt_sync  = sync_ff;
      nxt_level = level_ff;
      nxt_ready = ready_ff;
      nxt_init  = 1'b0;
      nxt_run   = run_ff;
      nxt_gsel  = gsel_ff;
      unique case (state_ff)
         scs_pkg::SCS_ST_INIT: begin
            // Host writes ignored until ready
            if (timer_done) begin // [RULE1]
               nxt_adr0  = `SCS_ADR_PTR0_RST;  // [RULE2]
               nxt_adr1  = `SCS_ADR_PTR1_RST;  // [RULE2]
               nxt_dport = `SCS_DATA_PORT_RST; // [RULE2]
               nxt_acq   = `SCS_ACQ_CTRL_RST;  // [RULE2]
               nxt_sync  = `SCS_SYNC_CFG_RST;  // [RULE2]
               nxt_level = `SCS_LEVEL_CHG_RST; // [RULE2]
               nxt_ready = 1'b1;
               nxt_state = scs_pkg::SCS_ST_HELD;
            end
         end
         scs_pkg::SCS_ST_HELD: begin
            if (sync_wr_i) begin
               // Select bits stored, not yet applied [RULE10]
               nxt_sync = sync_wdata_i;
            end
            if (level_wr_i) begin
               nxt_level = level_wdata_i;
               // High-to-low on hold starts the generator [RULE7]
               if (hold_now && !hold_req) begin
                  nxt_init  = 1'b1;
                  nxt_run   = 1'b1;
                  nxt_gsel  = {sync_ff[`SCS_SYNC_SEL1_POS], sync_ff[`SCS_SYNC_SEL0_POS]};
                  nxt_state = scs_pkg::SCS_ST_RUN;
               end
            end
         end
         scs_pkg::SCS_ST_RUN: begin
            if (sync_wr_i) begin
               nxt_sync = sync_wdata_i;
            end
            if (level_wr_i) begin
               // Hold bit stays cleared until reset [RULE8]
               nxt_level = level_wdata_i;
               nxt_level[`SCS_LEVEL_HOLD_POS] = 1'b0;
            end
         end
         default: begin
            // Illegal code: restart the sequence
            nxt_state = scs_pkg::SCS_ST_INIT;
         end
      endcase
      // Strong filter while ready and the bus-filter bit is low [RULE9]
      nxt_filt = ready_ff ? !nxt_sync[`SCS_SYNC_FILT_POS] : 1'b0;
   end

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_ff <= scs_pkg::SCS_ST_INIT;
         adr0_ff  <= `SCS_REG_CLEAR;
         adr1_ff  <= `SCS_REG_CLEAR;
         dport_ff <= `SCS_REG_CLEAR;
         acq_ff   <= `SCS_REG_CLEAR;
         sync_ff  <= `SCS_REG_CLEAR;
         level_ff <= `SCS_REG_CLEAR;
         ready_ff <= 1'b0;
         init_ff  <= 1'b0;
         run_ff   <= 1'b0;
         gsel_ff  <= 2'h0;
         filt_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         adr0_ff  <= nxt_adr0;
         adr1_ff  <= nxt_adr1;
         dport_ff <= nxt_dport;
         acq_ff   <= nxt_acq;
         sync_ff  <= nxt_sync;
         level_ff <= nxt_level;
         ready_ff <= nxt_ready;
         init_ff  <= nxt_init;
         run_ff   <= nxt_run;
         gsel_ff  <= nxt_gsel;
         filt_ff  <= nxt_filt;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   assign ready_o       = ready_ff;
   assign adr_ptr0_o    = adr0_ff;
   assign adr_ptr1_o    = adr1_ff;
   assign data_port_o   = dport_ff;
   assign acq_ctrl_o    = acq_ff;
   assign sync_cfg_o    = sync_ff;
   assign level_chg_o   = level_ff;
   assign clkgen_init_o = init_ff;
   assign clkgen_run_o  = run_ff;
   assign clkgen_sel_o  = gsel_ff;
   assign filter_max_o  = filt_ff;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   logic [15:0] since_rst_ff;  // Cycles since reset release, saturating
   logic [15:0] nxt_since_rst;

   // Next count, held at its top value
   always_comb begin
      nxt_since_rst = since_rst_ff;
      if (since_rst_ff != 16'hffff) begin
         nxt_since_rst = since_rst_ff + 16'h1;
      end
   end

   // Count register
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         since_rst_ff <= 16'h0;
      end else begin
         since_rst_ff <= nxt_since_rst;
      end
   end

   chk_ready_bound: assert property ( // [RULE1]
      @(posedge clk_i) disable iff (!resetn_i)
      (since_rst_ff >= 16'(INIT_CYCLES)) |-> ready_o)
      else $error("ready not raised within the init period");

   chk_ready_early: assert property ( // [RULE1]
      @(posedge clk_i) disable iff (!resetn_i)
      $rose(ready_o) |-> (since_rst_ff == 16'(INIT_CYCLES)))
      else $error("ready raised at the wrong cycle");

   chk_defaults_load: assert property ( // [RULE2]
      @(posedge clk_i) disable iff (!resetn_i)
      $rose(ready_o) |-> (sync_cfg_o == `SCS_SYNC_CFG_RST)
                         && (level_chg_o == `SCS_LEVEL_CHG_RST)
                         && (acq_ctrl_o == `SCS_ACQ_CTRL_RST)
                         && (adr_ptr0_o == `SCS_ADR_PTR0_RST)
                         && (adr_ptr1_o == `SCS_ADR_PTR1_RST)
                         && (data_port_o == `SCS_DATA_PORT_RST))
      else $error("defaults not loaded at ready");

   chk_release_start: assert property ( // [RULE7]
      @(posedge clk_i) disable iff (!resetn_i)
      (level_wr_i && ready_o && !clkgen_run_o && level_chg_o[`SCS_LEVEL_HOLD_POS]
       && !level_wdata_i[`SCS_LEVEL_HOLD_POS])
      |=> clkgen_init_o && clkgen_run_o
          && (clkgen_sel_o == {$past(sync_cfg_o[`SCS_SYNC_SEL1_POS]),
                               $past(sync_cfg_o[`SCS_SYNC_SEL0_POS])}))
      else $error("release did not start clock generation");

   chk_hold_sticky: assert property ( // [RULE8]
      @(posedge clk_i) disable iff (!resetn_i)
      clkgen_run_o |=> !level_chg_o[`SCS_LEVEL_HOLD_POS] && clkgen_run_o)
      else $error("hold bit set again after release");

   chk_filter_level: assert property ( // [RULE9]
      @(posedge clk_i) disable iff (!resetn_i)
      ready_o ##1 ready_o |-> (filter_max_o == !sync_cfg_o[`SCS_SYNC_FILT_POS]))
      else $error("filter strength does not follow bus-filter bit");

   chk_gen_held: assert property ( // [RULE10]
      @(posedge clk_i) disable iff (!resetn_i)
      !clkgen_run_o |-> !clkgen_init_o && (clkgen_sel_o == 2'h0))
      else $error("clock generation moved while held");
endmodule
`default_nettype wire

//--- verif/scs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Host controller driving the start-up steps
// ------------------------------------------
module scs_host_model (
   input  wire logic       clk_i,         // System clock
   input  wire logic       ready_i,       // Device ready
   input  wire logic [7:0] sync_cfg_i,    // Sync register readback
   output logic            sync_wr_o,     // Sync register write
   output logic [7:0]      sync_wdata_o,  // Sync register data
   output logic            level_wr_o,    // Level register write
   output logic [7:0]      level_wdata_o  // Level register data
);
   int tries; // Readback attempts

   // Idle port at time zero
   initial begin
      sync_wr_o = 1'b0;
      sync_wdata_o = 8'h5a;
      level_wr_o = 1'b0;
      level_wdata_o = 8'ha5;
   end

   // One write; data lines scrambled once the strobe drops
   task automatic put(input logic lvl, input logic [7:0] d);
      @(negedge clk_i);
      if (lvl) begin
         level_wr_o = 1'b1;
         level_wdata_o = d;
      end else begin
         sync_wr_o = 1'b1;
         sync_wdata_o = d;
      end
      @(negedge clk_i);
      level_wr_o = 1'b0;
      sync_wr_o = 1'b0;
      level_wdata_o = ~level_wdata_o;
      sync_wdata_o = ~sync_wdata_o;
   endtask

   // Full start-up; no register here lacks a default
   task automatic run(input logic [1:0] sel);
      int n;
      n = 0;
      while (ready_i !== 1'b1 && n < 2000) begin // No access before init ends
         @(negedge clk_i);
         n++;
      end
      tries = 0;
      do begin
         put(1'b0, {6'h20, sel}); // Select written first, filter high
         tries++;
      end while (sync_cfg_i[1:0] !== sel && tries < 4); // Readback compare
      put(1'b1, 8'h00); // Hold bit high to low
      put(1'b0, {6'h00, sel}); // Filter bit high to low
   endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ------------------------------------------
   // Stimulus, outputs and counters
   // ------------------------------------------
   localparam int unsigned INIT = 8; // Shortened self-init count
   logic       clk_i = 1'b0;     // 20 MHz clock
   logic       resetn_i = 1'b0;  // Reset, active low
   logic       sw = 1'b0;        // Bench sync write
   logic [7:0] sd = 8'h00;       // Bench sync data
   logic       lw = 1'b0;        // Bench level write
   logic [7:0] ld = 8'h00;       // Bench level data
   logic       hen = 1'b0;       // Host model owns the port
   logic       hsw;              // Host sync write
   logic [7:0] hsd;              // Host sync data
   logic       hlw;              // Host level write
   logic [7:0] hld;              // Host level data
   logic       ready, cinit, crun, fmax;
   logic [7:0] adr0, adr1, dport, acq, scfg, lchg, d;
   logic [1:0] csel;
   logic [7:0] inits = 8'h00;    // Clock start pulses seen
   int         seed, c, bad_count = 0, checked = 0, cyc = 0;
   wire logic       s_wr = hen ? hsw : sw;
   wire logic [7:0] s_d  = hen ? hsd : sd;
   wire logic       l_wr = hen ? hlw : lw;
   wire logic [7:0] l_d  = hen ? hld : ld;

   always #25 clk_i = ~clk_i;

   scs_seq #(.INIT_CYCLES(INIT)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .sync_wr_i(s_wr), .sync_wdata_i(s_d), .level_wr_i(l_wr), .level_wdata_i(l_d),
      .ready_o(ready), .adr_ptr0_o(adr0), .adr_ptr1_o(adr1), .data_port_o(dport),
      .acq_ctrl_o(acq), .sync_cfg_o(scfg), .level_chg_o(lchg), .clkgen_init_o(cinit),
      .clkgen_run_o(crun), .clkgen_sel_o(csel), .filter_max_o(fmax));

   scs_host_model host (.clk_i(clk_i), .ready_i(ready), .sync_cfg_i(scfg),
      .sync_wr_o(hsw), .sync_wdata_o(hsd), .level_wr_o(hlw), .level_wdata_o(hld));

   // Count start pulses since the last reset
   always @(negedge clk_i) begin
      if (resetn_i === 1'b0) begin
         inits <= 8'h00;
      end else if (cinit === 1'b1) begin
         inits <= inits + 8'h01;
      end
   end

   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         close_out();
      end
   end

   function automatic logic [7:0] exp_filt(input logic [7:0] v);
      return {7'h00, ~v[7]};
   endfunction

   function automatic logic [7:0] exp_run(input logic [1:0] s);
      return {5'h00, 1'b1, s};
   endfunction

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Write one register; idle cycle keeps strobes single-driven
   task automatic wr(input logic lvl, input logic [7:0] v);
      @(negedge clk_i);
      if (lvl) begin
         lw = 1'b1;
         ld = v;
      end else begin
         sw = 1'b1;
         sd = v;
      end
      @(negedge clk_i);
      lw = 1'b0;
      sw = 1'b0;
      ld = ~ld;
      sd = ~sd;
   endtask

   // Reset, then time the ready flag; a write during init is dropped
   task automatic do_reset;
      int k;
      resetn_i = 1'b0;
      repeat (3) @(negedge clk_i);
      resetn_i = 1'b1;
      for (k = 1; k <= INIT + 4; k++) begin
         sw = (k == 2);
         sd = 8'h03;
         @(negedge clk_i);
         chk("ready", {7'h00, k >= INIT}, {7'h00, ready});
         if (k < INIT) chk("sync_init", 8'h00, scfg);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------
   // Main sequence, one pass per clock source
   // ------------------------------------------
   initial begin
      seed = 32'hfd743c1c;
      for (c = 0; c < 4; c++) begin
         do_reset();
         chk("adr0", 8'h00, adr0);
         chk("adr1", 8'h00, adr1);
         chk("dport", 8'h00, dport);
         chk("acq", 8'h00, acq);
         chk("sync", 8'h80, scfg);
         chk("level", 8'h80, lchg);
         repeat (4) begin
            d = 8'($random(seed));
            wr(1'b0, d);
            chk("sync", d, scfg);
            chk("filter", exp_filt(d), {7'h00, fmax});
            d[7] = 1'b1;
            wr(1'b1, d);
            chk("level", d, lchg);
            chk("held", 8'h00, {5'h00, crun, csel});
         end
         hen = 1'b1;
         host.run(c[1:0]);
         hen = 1'b0;
         chk("run", exp_run(c[1:0]), {5'h00, crun, csel});
         chk("pulses", 8'h01, inits);
         chk("filter_on", 8'h01, {7'h00, fmax});
         wr(1'b1, 8'h80);
         chk("hold_stuck", 8'h00, lchg);
         wr(1'b0, {6'h00, ~c[1:0]});
         chk("sel_kept", {6'h00, c[1:0]}, {6'h00, csel});
         chk("pulses_again", 8'h01, inits);
         $display("test %0d done", c);
      end
      close_out();
   end
endmodule
`default_nettype wire
